// *** verilog/isoch_irq_regs.svh ***
`ifndef ISOCH_IRQ_REGS_SVH
`define ISOCH_IRQ_REGS_SVH

`define MAIN_EVENT_SET_OFS    8'h80
`define MAIN_EVENT_CLEAR_OFS  8'h84
`define MAIN_MASK_SET_OFS     8'h88
`define MAIN_MASK_CLEAR_OFS   8'h8C
`define ISO_EVENT_SET_OFS     8'h90
`define ISO_EVENT_CLEAR_OFS   8'h94
`define ISO_MASK_SET_OFS      8'h98
`define ISO_MASK_CLEAR_OFS    8'h9C

`define BIT_REQUEST_DONE      0
`define BIT_RESPONSE_DONE     1
`define BIT_ARQ_DMA           2
`define BIT_ARS_DMA           3
`define BIT_ISO_SUMMARY       6
`define BIT_GLOBAL_GATE       31

`define MAIN_EVENT_IMPL       4'hF
`define MAIN_MASK_IMPL        32'h8000_004F
`define ISO_MASK_IMPL         32'h0000_00FF
`define EVENT_RESET           32'h0000_0000
`define MASK_RESET            32'h0000_0000
`define INT_CTL_ENABLED       2'h3

`endif

// *** verilog/isoch_irq_pkg.sv ***
package isoch_irq_pkg;

   typedef logic [31:0] word_t;

   typedef enum logic [3:0] {
      SEL_NONE,
      SEL_MAIN_EVENT_SET,
      SEL_MAIN_EVENT_CLEAR,
      SEL_MAIN_MASK_SET,
      SEL_MAIN_MASK_CLEAR,
      SEL_ISO_EVENT_SET,
      SEL_ISO_EVENT_CLEAR,
      SEL_ISO_MASK_SET,
      SEL_ISO_MASK_CLEAR
   } reg_sel_t;

endpackage : isoch_irq_pkg

// *** verilog/sticky_event_bank.sv ***
`timescale 1ns/10ps

module sticky_event_bank #(
   parameter int WIDTH = 8
) (
   input  wire logic             clock,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] source,
   input  wire logic [WIDTH-1:0] set_wr,
   input  wire logic [WIDTH-1:0] clear_wr,
   output logic      [WIDTH-1:0] event_q
);

   logic [WIDTH-1:0] source_q;
   logic [WIDTH-1:0] rise;
   logic [WIDTH-1:0] event_d;

   always_ff @(posedge clock) begin
      if (reset) begin
         source_q <= '0;
      end else begin
         source_q <= source;
      end
   end

   // Edge, not level: a held source cannot re-set after a clear
   assign rise = source & ~source_q;

   // Set wins over a clear in the same cycle
   assign event_d = (event_q & ~clear_wr) | rise | set_wr;

   always_ff @(posedge clock) begin
      if (reset) begin
         event_q <= '0;
      end else begin
         event_q <= event_d;
      end
   end

endmodule : sticky_event_bank

// *** verilog/set_clear_mask.sv ***
`timescale 1ns/10ps

module set_clear_mask #(
   parameter logic [31:0] IMPL = 32'hFFFF_FFFF
) (
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic [31:0] set_wr,
   input  wire logic [31:0] clear_wr,
   output logic      [31:0] mask_q
);

   logic [31:0] mask_d;

   // Unimplemented positions never hold state
   assign mask_d = ((mask_q & ~clear_wr) | set_wr) & IMPL;

   always_ff @(posedge clock) begin
      if (reset) begin
         mask_q <= '0;
      end else begin
         mask_q <= mask_d;
      end
   end

endmodule : set_clear_mask

// *** verilog/isoch_tx_interrupt_event_mask.sv ***
`timescale 1ns/10ps

`include "isoch_irq_regs.svh"

// Functional notes
// - Rx response DMA interrupt needs mask bit 3 and event bit 3 set.
// - Rx request DMA interrupt needs mask bit 2 and event bit 2 set.
// - Response send done interrupt needs mask bit 1 and event bit 1.
// - Request send done interrupt needs mask bit 0 and event bit 0.
// - One event bit per isochronous send context, eight in all.
// - Context event when last-output command ends with interrupt bits 11.
// - Event bit sets on rising context signal or write one to set.
// - Only a one written to the clear register clears an event bit.
// - Reading the clear address returns events ANDed with context mask.
// - Event bits 31 to 8 read zero and hold nothing.
// - Event bit n says context n caused the summary bit 6.
// - Separate context mask, readable at its set and clear addresses.
// - Global gate bit 31 low blocks irq; isoch_send_summary_event is not gated.
module isoch_tx_interrupt_event_mask
   import isoch_irq_pkg::*;
#(
   parameter int CONTEXTS = 8,
   parameter int ADDR_W   = 8
) (
   input  wire logic                  clock,
   input  wire logic                  reset,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [ADDR_W-1:0]     paddr,
   input  wire logic [31:0]           pwdata,
   input  wire logic [3:0]            pstrb,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic                  async_rx_response_dma_event,
   input  wire logic                  async_rx_request_dma_event,
   input  wire logic                  response_send_done,
   input  wire logic                  request_send_done,
   input  wire logic [CONTEXTS-1:0]   ctx_last_done,
   input  wire logic [2*CONTEXTS-1:0] ctx_int_ctl,
   output logic                       isoch_send_summary_event,
   output logic                       irq
);

   reg_sel_t            sel;
   logic                mapped;
   logic                setup_phase;
   logic                access_done;
   logic                wr_en;

   logic [31:0]         wdata_eff;

   logic [31:0]         main_ev_set_wr;
   logic [31:0]         main_ev_clr_wr;
   logic [31:0]         main_mk_set_wr;
   logic [31:0]         main_mk_clr_wr;
   logic [31:0]         iso_ev_set_wr;
   logic [31:0]         iso_ev_clr_wr;
   logic [31:0]         iso_mk_set_wr;
   logic [31:0]         iso_mk_clr_wr;

   logic [3:0]          main_src;
   logic [3:0]          main_event;
   logic [CONTEXTS-1:0] ctx_signal;
   logic [CONTEXTS-1:0] iso_event;

   logic [31:0]         main_mask;
   logic [31:0]         iso_mask;

   word_t               main_event_word;
   word_t               iso_event_word;
   word_t               read_word;

   logic                summary_now;
   logic                irq_now;

   logic [31:0]         prdata_q;
   logic                pready_q;
   logic                pslverr_q;
   logic                summary_q;
   logic                irq_q;

   // Helpers shared by decode, strobes and lanes
   function automatic logic addr_is(
      input logic [ADDR_W-1:0] addr,
      input logic [7:0]        ofs
   );
      addr_is = (addr == ADDR_W'(ofs));
   endfunction : addr_is

   function automatic logic [31:0] write_bits(
      input logic        hit,
      input logic [31:0] data
   );
      write_bits = hit ? data : 32'h0000_0000;
   endfunction : write_bits

   function automatic logic [31:0] lane_mask(input logic [3:0] strb);
      lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
   endfunction : lane_mask

   // Address decode
   always_comb begin
      if (addr_is(paddr, `MAIN_EVENT_SET_OFS)) begin
         sel = SEL_MAIN_EVENT_SET;
      end else if (addr_is(paddr, `MAIN_EVENT_CLEAR_OFS)) begin
         sel = SEL_MAIN_EVENT_CLEAR;
      end else if (addr_is(paddr, `MAIN_MASK_SET_OFS)) begin
         sel = SEL_MAIN_MASK_SET;
      end else if (addr_is(paddr, `MAIN_MASK_CLEAR_OFS)) begin
         sel = SEL_MAIN_MASK_CLEAR;
      end else if (addr_is(paddr, `ISO_EVENT_SET_OFS)) begin
         sel = SEL_ISO_EVENT_SET;
      end else if (addr_is(paddr, `ISO_EVENT_CLEAR_OFS)) begin
         sel = SEL_ISO_EVENT_CLEAR;
      end else if (addr_is(paddr, `ISO_MASK_SET_OFS)) begin
         sel = SEL_ISO_MASK_SET;
      end else if (addr_is(paddr, `ISO_MASK_CLEAR_OFS)) begin
         sel = SEL_ISO_MASK_CLEAR;
      end else begin
         sel = SEL_NONE;
      end
   end

   // Unmapped offsets answer with an error and write nothing
   assign mapped      = (sel != SEL_NONE);
   assign setup_phase = psel & ~penable;
   assign access_done = psel & penable & pready_q;
   assign wr_en       = access_done & pwrite & mapped;

   // Lanes with a low strobe write nothing, which is a no-op here
   assign wdata_eff = pwdata & lane_mask(pstrb);

   // Write strobes into each set and clear port
   assign main_ev_set_wr = write_bits(wr_en & (sel == SEL_MAIN_EVENT_SET),
                                      wdata_eff);
   assign main_ev_clr_wr = write_bits(wr_en & (sel == SEL_MAIN_EVENT_CLEAR),
                                      wdata_eff);
   assign main_mk_set_wr = write_bits(wr_en & (sel == SEL_MAIN_MASK_SET),
                                      wdata_eff);
   assign main_mk_clr_wr = write_bits(wr_en & (sel == SEL_MAIN_MASK_CLEAR),
                                      wdata_eff);
   assign iso_ev_set_wr  = write_bits(wr_en & (sel == SEL_ISO_EVENT_SET),
                                      wdata_eff);
   assign iso_ev_clr_wr  = write_bits(wr_en & (sel == SEL_ISO_EVENT_CLEAR),
                                      wdata_eff);
   assign iso_mk_set_wr  = write_bits(wr_en & (sel == SEL_ISO_MASK_SET),
                                      wdata_eff);
   assign iso_mk_clr_wr  = write_bits(wr_en & (sel == SEL_ISO_MASK_CLEAR),
                                      wdata_eff);

   // Main event sources, bit order as in the event register
   assign main_src[`BIT_ARS_DMA]       = async_rx_response_dma_event;
   assign main_src[`BIT_ARQ_DMA]       = async_rx_request_dma_event;
   assign main_src[`BIT_RESPONSE_DONE] = response_send_done;
   assign main_src[`BIT_REQUEST_DONE]  = request_send_done;

   // Main sources are edge triggered, like the contexts
   sticky_event_bank #(
      .WIDTH    (4)
   ) u_main_event (
      .clock    (clock),
      .reset    (reset),
      .source   (main_src),
      .set_wr   (main_ev_set_wr[3:0]),
      .clear_wr (main_ev_clr_wr[3:0]),
      .event_q  (main_event)
   );

   // Context signal: last-output end with both interrupt bits set
   always_comb begin
      ctx_signal = '0;
      for (int n = 0; n < CONTEXTS; n++) begin
         ctx_signal[n] = ctx_last_done[n] &
                         (ctx_int_ctl[2*n +: 2] == `INT_CTL_ENABLED);
      end
   end

   // One sticky bit per context, set on edge or write, write-one clear
   sticky_event_bank #(
      .WIDTH    (CONTEXTS)
   ) u_iso_event (
      .clock    (clock),
      .reset    (reset),
      .source   (ctx_signal),
      .set_wr   (iso_ev_set_wr[CONTEXTS-1:0]),
      .clear_wr (iso_ev_clr_wr[CONTEXTS-1:0]),
      .event_q  (iso_event)
   );

   // Only bits 31, 6 and 3:0 of the main mask hold state
   set_clear_mask #(
      .IMPL     (`MAIN_MASK_IMPL)
   ) u_main_mask (
      .clock    (clock),
      .reset    (reset),
      .set_wr   (main_mk_set_wr),
      .clear_wr (main_mk_clr_wr),
      .mask_q   (main_mask)
   );

   set_clear_mask #(
      .IMPL     (`ISO_MASK_IMPL)
   ) u_iso_mask (
      .clock    (clock),
      .reset    (reset),
      .set_wr   (iso_mk_set_wr),
      .clear_wr (iso_mk_clr_wr),
      .mask_q   (iso_mask)
   );

   // Summary is derived, so it falls as soon as contexts are cleared
   assign summary_now = |(iso_event & iso_mask[CONTEXTS-1:0]);

   // Bit 6 is not stored, so it cannot disagree with the contexts
   always_comb begin
      main_event_word                   = 32'h0000_0000;
      main_event_word[3:0]              = main_event;
      main_event_word[`BIT_ISO_SUMMARY] = summary_now;
   end

   // Upper bits are constant zero, never state
   always_comb begin
      iso_event_word                 = 32'h0000_0000;
      iso_event_word[CONTEXTS-1:0]   = iso_event;
   end

   // Each source needs its own mask and event bit, then the gate
   always_comb begin
      irq_now = 1'b0;
      if (main_mask[`BIT_ARS_DMA] & main_event[`BIT_ARS_DMA]) begin
         irq_now = 1'b1;
      end
      if (main_mask[`BIT_ARQ_DMA] & main_event[`BIT_ARQ_DMA]) begin
         irq_now = 1'b1;
      end
      if (main_mask[`BIT_RESPONSE_DONE] &
          main_event[`BIT_RESPONSE_DONE]) begin
         irq_now = 1'b1;
      end
      if (main_mask[`BIT_REQUEST_DONE] &
          main_event[`BIT_REQUEST_DONE]) begin
         irq_now = 1'b1;
      end
      if (main_mask[`BIT_ISO_SUMMARY] & summary_now) begin
         irq_now = 1'b1;
      end
      if (!main_mask[`BIT_GLOBAL_GATE]) begin
         irq_now = 1'b0;
      end
   end

   // Read mux
   always_comb begin
      case (sel)
         SEL_MAIN_EVENT_SET: begin
            read_word = main_event_word;
         end
         SEL_MAIN_EVENT_CLEAR: begin
            read_word = main_event_word & main_mask;
         end
         SEL_MAIN_MASK_SET,
         SEL_MAIN_MASK_CLEAR: begin
            read_word = main_mask;
         end
         SEL_ISO_EVENT_SET: begin
            read_word = iso_event_word;
         end
         SEL_ISO_EVENT_CLEAR: begin
            read_word = iso_event_word & iso_mask;
         end
         SEL_ISO_MASK_SET,
         SEL_ISO_MASK_CLEAR: begin
            read_word = iso_mask;
         end
         default: begin
            read_word = 32'h0000_0000;
         end
      endcase
   end

   // One wait-free access: ready is raised by the setup cycle
   always_ff @(posedge clock) begin
      if (reset) begin
         pready_q <= 1'b0;
      end else if (setup_phase) begin
         pready_q <= 1'b1;
      end else begin
         pready_q <= 1'b0;
      end
   end

   // Data sampled at setup; it may lag an event of that same cycle
   always_ff @(posedge clock) begin
      if (reset) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup_phase && !pwrite) begin
         prdata_q <= read_word;
      end else if (access_done) begin
         prdata_q <= 32'h0000_0000;
      end
   end

   // Error flag stands with ready for one cycle only
   always_ff @(posedge clock) begin
      if (reset) begin
         pslverr_q <= 1'b0;
      end else if (setup_phase) begin
         pslverr_q <= ~mapped;
      end else begin
         pslverr_q <= 1'b0;
      end
   end

   // Registered so that every output leaves a flip-flop
   always_ff @(posedge clock) begin
      if (reset) begin
         summary_q <= 1'b0;
      end else begin
         summary_q <= summary_now;
      end
   end

   // One cycle behind the state bits that it reports
   always_ff @(posedge clock) begin
      if (reset) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_now;
      end
   end

   assign prdata                   = prdata_q;
   assign pready                   = pready_q;
   assign pslverr                  = pslverr_q;
   assign isoch_send_summary_event = summary_q;
   assign irq                      = irq_q;

endmodule : isoch_tx_interrupt_event_mask

// *** sim/isoch_irq_properties.sv ***
`timescale 1ns/10ps

module isoch_irq_properties
   import isoch_irq_pkg::*;
#(
   parameter int CONTEXTS = 8,
   parameter int ADDR_W   = 8
) (
   input wire logic                  clock,
   input wire logic                  reset,
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [ADDR_W-1:0]     paddr,
   input wire logic [31:0]           pwdata,
   input wire logic [3:0]            pstrb,
   input wire logic [31:0]           prdata,
   input wire logic                  pready,
   input wire logic                  pslverr,
   input wire logic                  async_rx_response_dma_event,
   input wire logic                  async_rx_request_dma_event,
   input wire logic                  response_send_done,
   input wire logic                  request_send_done,
   input wire logic [CONTEXTS-1:0]   ctx_last_done,
   input wire logic [2*CONTEXTS-1:0] ctx_int_ctl,
   input wire logic                  isoch_send_summary_event,
   input wire logic                  irq
);
   logic wr_acc;
   logic unmap;
   assign wr_acc = psel & penable & pwrite & pready;
   assign unmap  = !(paddr[7:5] == 3'h4 && paddr[1:0] == 2'h0);

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   sequence setup_s;
      psel && !penable;
   endsequence
   sequence iso_rd_s;
      setup_s ##0 (!pwrite && paddr[7:3] == 5'h12);
   endsequence

   pready_after_setup_a: assert property (setup_s |=> pready)
      else $error("pready missing after setup");
   pready_single_a: assert property (pready |=> !pready)
      else $error("pready stood two cycles");
   slverr_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata nonzero while idle");
   unmap_err_a: assert property (setup_s |=> pslverr == $past(unmap))
      else $error("pslverr does not follow address");
   iso_rsvd_a: assert property (iso_rd_s |=> prdata[31:8] == 24'h0)
      else $error("upper event bits read nonzero");
   summary_fall_a: assert property ($fell(isoch_send_summary_event)
      |-> $past(wr_acc, 2)) else $error("summary fell without write");
   summary_rise_a: assert property ($rose(isoch_send_summary_event)
      |-> $past(wr_acc, 2) || $past(ctx_last_done, 2) != 0)
      else $error("summary rose without cause");
   irq_fall_a: assert property ($fell(irq)
      |-> $past(wr_acc, 2) || $past(wr_acc, 3))
      else $error("irq fell without write");
endmodule : isoch_irq_properties

bind isoch_tx_interrupt_event_mask isoch_irq_properties #(
   .CONTEXTS(CONTEXTS), .ADDR_W(ADDR_W)) props_u (
   .clock(clock), .reset(reset), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .async_rx_response_dma_event(async_rx_response_dma_event),
   .async_rx_request_dma_event(async_rx_request_dma_event),
   .response_send_done(response_send_done),
   .request_send_done(request_send_done),
   .ctx_last_done(ctx_last_done), .ctx_int_ctl(ctx_int_ctl),
   .isoch_send_summary_event(isoch_send_summary_event), .irq(irq));

// *** sim/test_isoch_tx_interrupt_event_mask.sv ***
`timescale 1ns/10ps
`include "isoch_irq_regs.svh"

module test_isoch_tx_interrupt_event_mask
   import isoch_irq_pkg::*;
();
   logic        clock, reset, psel, penable, pwrite, pready, pslverr;
   logic        summ, irq, e;
   logic [7:0]  paddr, done, ev, mk;
   logic [3:0]  pstrb, msrc, mev, stb;
   logic [15:0] ictl;
   word_t       pwdata, prdata, mm, r;
   int          err_total, checked;

   isoch_tx_interrupt_event_mask dut_u (
      .clock(clock), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .async_rx_response_dma_event(msrc[3]),
      .async_rx_request_dma_event(msrc[2]),
      .response_send_done(msrc[1]), .request_send_done(msrc[0]),
      .ctx_last_done(done), .ctx_int_ctl(ictl),
      .isoch_send_summary_event(summ), .irq(irq));

   always #4 clock = ~clock;

   task automatic chk(input word_t seen, input word_t exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_sim

   function automatic word_t exp_rd(input logic [7:0] a);
      word_t m;
      m = {25'h0, |(ev & mk), 2'h0, mev};
      case (a)
         `MAIN_EVENT_SET_OFS: return m;
         `MAIN_EVENT_CLEAR_OFS: return m & mm;
         `MAIN_MASK_SET_OFS, `MAIN_MASK_CLEAR_OFS: return mm;
         `ISO_EVENT_SET_OFS: return {24'h0, ev};
         `ISO_EVENT_CLEAR_OFS: return {24'h0, ev & mk};
         `ISO_MASK_SET_OFS, `ISO_MASK_CLEAR_OFS: return {24'h0, mk};
         default: return 32'h0;
      endcase
   endfunction : exp_rd

   function automatic logic exp_irq();
      return mm[31] & |(exp_rd(`MAIN_EVENT_CLEAR_OFS) & 32'h4F);
   endfunction : exp_irq

   // Answer taken at the rising edge that samples ready high
   task automatic apb(input logic w, input logic [7:0] a, input word_t d);
      int n;
      @(posedge clock);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= stb;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk({31'h0, pready}, 32'h1);
      r = prdata;
      e = pslverr;
      @(posedge clock);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input word_t d);
      apb(1'b1, a, d);
      d &= {{8{stb[3]}}, {8{stb[2]}}, {8{stb[1]}}, {8{stb[0]}}};
      case (a)
         `MAIN_EVENT_SET_OFS: mev |= d[3:0];
         `MAIN_EVENT_CLEAR_OFS: mev &= ~d[3:0];
         `MAIN_MASK_SET_OFS: mm |= d & `MAIN_MASK_IMPL;
         `MAIN_MASK_CLEAR_OFS: mm &= ~d;
         `ISO_EVENT_SET_OFS: ev |= d[7:0];
         `ISO_EVENT_CLEAR_OFS: ev &= ~d[7:0];
         `ISO_MASK_SET_OFS: mk |= d[7:0];
         `ISO_MASK_CLEAR_OFS: mk &= ~d[7:0];
         default: ;
      endcase
   endtask : wr

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, $urandom);
      chk(r, exp_rd(a));
      chk({31'h0, e}, {31'h0, !(a[7:5] == 3'h4 && a[1:0] == 2'h0)});
   endtask : rd

   task automatic outs();
      repeat (4) @(posedge clock);
      @(negedge clock);
      chk({31'h0, summ}, {31'h0, |(ev & mk)});
      chk({31'h0, irq}, {31'h0, exp_irq()});
   endtask : outs

   task automatic pulse(input logic [3:0] s, input logic [7:0] c,
                        input logic [15:0] t);
      @(posedge clock);
      msrc <= s;
      done <= c;
      ictl <= t;
      @(posedge clock);
      msrc <= 4'h0;
      done <= 8'h0;
      mev |= s;
      for (int n = 0; n < 8; n++)
         if (c[n] && t[2*n+:2] == `INT_CTL_ENABLED) ev[n] = 1'b1;
   endtask : pulse

   initial begin
      {clock, psel, penable, pwrite, paddr, pwdata, msrc, done} = '0;
      {ictl, ev, mk, mev, mm, err_total, checked} = '0;
      reset = 1'b1;
      pstrb = 4'hF;
      stb = 4'hF;
      void'($urandom(32'hCC4C));
      repeat (20) @(posedge clock);
      reset <= 1'b0;
      for (int i = 0; i < 9; i++) rd(8'(128 + 4 * i));
      wr(8'hA0, 32'hFFFF_FFFF);
      rd(8'h92);
      $display("test reset values done");
      wr(`ISO_MASK_SET_OFS, 32'hFF);
      for (int b = 0; b < 4; b++) begin
         pulse(4'hF, 8'h0, 16'h0);
         wr(`MAIN_MASK_CLEAR_OFS, 32'hFFFF_FFFF);
         wr(`MAIN_MASK_SET_OFS, 32'h1 << b);
         outs();
         wr(`MAIN_MASK_SET_OFS, 32'h8000_0000);
         outs();
         wr(`MAIN_EVENT_CLEAR_OFS, 32'h1 << b);
         outs();
         rd(`MAIN_EVENT_CLEAR_OFS);
      end
      $display("test main mask done");
      wr(`MAIN_MASK_SET_OFS, 32'h8000_0040);
      wr(`MAIN_EVENT_CLEAR_OFS, 32'hF);
      for (int n = 0; n < 8; n++) begin
         pulse(4'h0, 8'h1 << n, n[0] ? 16'hFFFF : 16'($urandom));
         outs();
         rd(`ISO_EVENT_SET_OFS);
      end
      $display("test context events done");
      wr(`ISO_EVENT_SET_OFS, 32'hFFFF_FFFF);
      wr(`ISO_EVENT_CLEAR_OFS, 32'h0);
      wr(`ISO_MASK_CLEAR_OFS, 32'hF0);
      for (int i = 0; i < 8; i++) rd(8'(128 + 4 * i));
      outs();
      wr(`ISO_EVENT_CLEAR_OFS, 32'h0F);
      outs();
      $display("test set clear done");
      @(posedge clock);
      reset <= 1'b1;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      {ev, mk, mev, mm} = '0;
      rd(`ISO_EVENT_SET_OFS);
      outs();
      $display("test second reset done");
      for (int i = 0; i < 60; i++) begin
         stb = 4'($urandom);
         if ($urandom % 3 == 0)
            pulse(4'($urandom), 8'($urandom), 16'($urandom));
         else wr(8'(128 + 4 * ($urandom % 8)), $urandom);
         outs();
         rd(8'(128 + 4 * ($urandom % 8)));
      end
      $display("test random done");
      end_sim();
   end

   // Whole run needs about a thousand cycles
   initial begin
      #100000;
      chk(32'h0, 32'h1);
      end_sim();
   end
endmodule : test_isoch_tx_interrupt_event_mask
